// ==== design/iser_status_core.sv ====
// Purpose: Standard event and questionable latches, summary bits, message available
// Assumes: Command and event strobes are one-cycle pulses on clk_i
// Notes:   sys_rst_i is the power-on reset; device clear never reaches the latches
`timescale 1ns/10ps
`include "iser_defines.svh"
module iser_status_core
    import iser_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   ce_i,
    input  wire iser_cmd_t              cmd_i,
    input  wire logic [7:0]             ese_wdata_i,
    input  wire logic [15:0]            qen_wdata_i,
    input  wire logic                   psc_setting_i,
    input  wire logic [7:0]             ese_retained_i,
    input  wire logic                   cmds_idle_i,
    input  wire iser_evt_t              evt_i,
    input  wire logic                   reading_trigger_i,
    input  wire logic                   meas_all_done_i,
    input  wire logic                   reading_push_i,
    input  wire logic                   query_push_i,
    input  wire logic                   host_read_i,
    input  wire logic                   new_line_i,
    input  wire logic                   in_buf_full_i,
    output logic      [7:0]             esr_o,
    output logic      [15:0]            ques_o,
    output logic      [7:0]             ese_o,
    output logic      [15:0]            qen_o,
    output logic      [7:0]             stb_o,
    output logic                        mav_o,
    output logic                        err_push_o,
    output logic      [7:0]             err_code_o,
    output logic                        reading_halt_o,
    output logic                        opc_pending_o,
    output logic                        out_full_o
);

    logic                  boot;
    logic                  opc_pend;
    logic                  opc_fire;
    logic [7:0]            esr_set;
    logic [15:0]           ques_set;
    logic                  ese_wr;
    logic [7:0]            ese_wdata;
    logic                  ese_clr;
    logic                  esb_sum;
    logic                  qsum;
    logic                  any_ovld;
    logic                  qry_err;
    logic                  read_empty;
    logic                  overrun;
    logic                  both_full;
    logic                  out_full;
    logic                  push_ok;
    logic                  pop_ok;
    logic                  msg_push;
    logic [`ISER_CNT_W-1:0] msg_count;
    logic [`ISER_CNT_W-1:0] next_msg_count;
    logic                  mav_set;
    logic                  next_mav;
    logic [7:0]            err_bits;
    iser_mav_state_t       mav_state;
    iser_mav_state_t       next_mav_state;

    // First enabled cycle after power-on applies the stored mask when the stored setting is 0
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            boot <= 1'b1;
        end else if (ce_i) begin
            boot <= 1'b0;
        end
    end

    // Stored setting 0 keeps the mask, setting 1 leaves the cleared reset value
    assign ese_wr    = cmd_i.ese_write || (boot && !psc_setting_i);
    assign ese_wdata = cmd_i.ese_write ? ese_wdata_i : ese_retained_i;
    assign ese_clr   = 1'b0;

    // OPC waits for every earlier command to finish
    assign opc_fire = (opc_pend || cmd_i.opc) && cmds_idle_i;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            opc_pend <= 1'b0;
        end else if (ce_i) begin
            opc_pend <= (opc_pend || cmd_i.opc) && !cmds_idle_i;
        end
    end

    // Output buffer bookkeeping
    assign out_full   = (msg_count == `ISER_OUTBUF_DEPTH);
    assign msg_push   = reading_push_i || query_push_i;
    assign push_ok    = msg_push && (!out_full || host_read_i);
    assign pop_ok     = host_read_i && (msg_count != '0);

    iser_msg_count #(
        .W            (`ISER_CNT_W)
    ) u_msg_count (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .ce_i         (ce_i),
        .push_i       (push_ok),
        .pop_i        (pop_ok),
        .count_o      (msg_count),
        .next_count_o (next_msg_count)
    );

    // Three query error causes
    assign read_empty = host_read_i && (msg_count == '0) && !msg_push;
    assign overrun    = new_line_i && (msg_count != '0);
    assign both_full  = in_buf_full_i && out_full;
    assign qry_err    = read_empty || overrun || both_full;

    assign any_ovld   = evt_i.volt_ovld || evt_i.temp_ovld || evt_i.ohm_ovld;

    // Standard event sources; bits 1 and 6 never set
    always_comb begin
        esr_set                    = 8'h00;
        esr_set[`ISER_ESR_OPC]     = opc_fire;
        esr_set[`ISER_ESR_QUERY]   = qry_err;
        esr_set[`ISER_ESR_DEVICE]  = evt_i.self_test_fail || evt_i.cal_fail
                                     || any_ovld;
        esr_set[`ISER_ESR_EXEC]    = evt_i.exec_fail;
        esr_set[`ISER_ESR_COMMAND] = evt_i.syntax_err;
    end

    // Overload bits at weights 1, 16, 512
    always_comb begin
        ques_set                  = 16'h0000;
        ques_set[`ISER_QUES_VOLT] = evt_i.volt_ovld;
        ques_set[`ISER_QUES_TEMP] = evt_i.temp_ovld;
        ques_set[`ISER_QUES_OHM]  = evt_i.ohm_ovld;
    end

    // Power-on flag comes from the reset value of the latch
    iser_event_latch #(
        .W         (8),
        .USED      (`ISER_ESR_USED),
        .EVT_RESET (`ISER_ESR_RESET),
        .EN_RESET  (`ISER_ESE_RESET)
    ) u_std_event (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .set_i     (esr_set),
        .clr_i     (cmd_i.cls || cmd_i.esr_query),
        .en_wr_i   (ese_wr),
        .en_data_i (ese_wdata),
        .en_clr_i  (ese_clr),
        .evt_o     (esr_o),
        .en_o      (ese_o),
        .sum_o     (esb_sum)
    );

    // Questionable mask cleared at power-up whatever the stored setting
    iser_event_latch #(
        .W         (16),
        .USED      (`ISER_QUES_USED),
        .EVT_RESET (`ISER_QUES_RESET),
        .EN_RESET  (`ISER_QEN_RESET)
    ) u_ques_event (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .set_i     (ques_set),
        .clr_i     (cmd_i.cls || cmd_i.ques_query),
        .en_wr_i   (cmd_i.qen_write),
        .en_data_i (qen_wdata_i),
        .en_clr_i  (cmd_i.preset),
        .evt_o     (ques_o),
        .en_o      (qen_o),
        .sum_o     (qsum)
    );

    // Error queue entry for every error flag except overloads
    always_comb begin
        err_bits                    = 8'h00;
        err_bits[`ISER_ESR_QUERY]   = qry_err;
        err_bits[`ISER_ESR_DEVICE]  = evt_i.self_test_fail || evt_i.cal_fail;
        err_bits[`ISER_ESR_EXEC]    = evt_i.exec_fail;
        err_bits[`ISER_ESR_COMMAND] = evt_i.syntax_err;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            err_push_o <= 1'b0;
            err_code_o <= 8'h00;
        end else if (ce_i) begin
            err_push_o <= |err_bits;
            err_code_o <= err_bits;
        end
    end

    // Message-available sequencing
    always_comb begin
        next_mav_state = mav_state;
        mav_set        = query_push_i;
        case (mav_state)
            ISER_MAV_IDLE: begin
                if (cmd_i.read_cmd) begin
                    next_mav_state = ISER_MAV_WAIT_FIRST;
                end else if (cmd_i.init_cmd) begin
                    next_mav_state = ISER_MAV_WAIT_ALL;
                end
            end
            ISER_MAV_WAIT_FIRST: begin
                // Later readings of the same request are not tracked
                if (reading_trigger_i) begin
                    mav_set        = 1'b1;
                    next_mav_state = ISER_MAV_IDLE;
                end
            end
            ISER_MAV_WAIT_ALL: begin
                // Stored readings only count once the whole run is done
                if (meas_all_done_i) begin
                    mav_set        = 1'b1;
                    next_mav_state = ISER_MAV_IDLE;
                end
            end
            default: begin
                next_mav_state = ISER_MAV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mav_state <= ISER_MAV_IDLE;
        end else if (ce_i) begin
            mav_state <= next_mav_state;
        end
    end

    // Drops only on the read that drains the buffer; a new set wins
    assign next_mav = mav_set || (mav_o && !(host_read_i && (next_msg_count == '0)));

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mav_o <= 1'b0;
        end else if (ce_i) begin
            mav_o <= next_mav;
        end
    end

    // Status byte summary bits; request service and operation bits are left out
    // Wired from the summary flops: another stage would make summaries lag
    always_comb begin
        stb_o                 = 8'h00;
        stb_o[`ISER_STB_QSUM] = qsum;
        stb_o[`ISER_STB_MAV]  = mav_o;
        stb_o[`ISER_STB_ESB]  = esb_sum;
    end

    // Reading engine stalls while OPC waits and the buffer is full
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reading_halt_o <= 1'b0;
            opc_pending_o  <= 1'b0;
            out_full_o     <= 1'b0;
        end else if (ce_i) begin
            reading_halt_o <= (opc_pend || cmd_i.opc) && !cmds_idle_i
                              && (next_msg_count == `ISER_OUTBUF_DEPTH);
            opc_pending_o  <= (opc_pend || cmd_i.opc) && !cmds_idle_i;
            out_full_o     <= (next_msg_count == `ISER_OUTBUF_DEPTH);
        end
    end

endmodule : iser_status_core

// ==== design/iser_defines.svh ====
// Purpose: Constants of the status and event reporting block
// Assumes: One clock, power-on reset on sys_rst_i
// Notes:   Offsets are bit positions; the registers have no bus address
`ifndef ISER_DEFINES_SVH
`define ISER_DEFINES_SVH

`define ISER_ESR_OPC       0
`define ISER_ESR_QUERY     2
`define ISER_ESR_DEVICE    3
`define ISER_ESR_EXEC      4
`define ISER_ESR_COMMAND   5
`define ISER_ESR_POWER_ON  7
`define ISER_ESR_USED      8'hbd
`define ISER_ESR_RESET     8'h80
`define ISER_ESE_RESET     8'h00

`define ISER_QUES_VOLT     0
`define ISER_QUES_TEMP     4
`define ISER_QUES_OHM      9
`define ISER_QUES_USED     16'h0211
`define ISER_QUES_RESET    16'h0000
`define ISER_QEN_RESET     16'h0000

`define ISER_STB_QSUM      3
`define ISER_STB_MAV       4
`define ISER_STB_ESB       5

`define ISER_OUTBUF_DEPTH  5'h10
`define ISER_CNT_W         5

`endif

// ==== design/iser_pkg.sv ====
// Purpose: Types shared by the status and event reporting block
// Assumes: Command strobes come from a parser on the same clock
// Notes:   Every strobe is a one-cycle pulse
package iser_pkg;

    typedef struct packed {
        logic cls;
        logic esr_query;
        logic ques_query;
        logic ese_write;
        logic qen_write;
        logic preset;
        logic opc;
        logic read_cmd;
        logic init_cmd;
    } iser_cmd_t;

    typedef struct packed {
        logic self_test_fail;
        logic cal_fail;
        logic exec_fail;
        logic syntax_err;
        logic volt_ovld;
        logic temp_ovld;
        logic ohm_ovld;
    } iser_evt_t;

    typedef enum logic [1:0] {
        ISER_MAV_IDLE,
        ISER_MAV_WAIT_FIRST,
        ISER_MAV_WAIT_ALL
    } iser_mav_state_t;

endpackage : iser_pkg

// ==== design/iser_event_latch.sv ====
// Purpose: One event register with its enable mask and summary bit
// Assumes: Set, clear and enable strobes on the same clock
// Notes:   Summary is registered from next values, so it moves with the latch
`timescale 1ns/10ps
module iser_event_latch #(
    parameter int          W          = 8,
    parameter logic [W-1:0] USED      = '1,
    parameter logic [W-1:0] EVT_RESET = '0,
    parameter logic [W-1:0] EN_RESET  = '0
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic         clr_i,
    input  wire logic         en_wr_i,
    input  wire logic [W-1:0] en_data_i,
    input  wire logic         en_clr_i,
    output logic      [W-1:0] evt_o,
    output logic      [W-1:0] en_o,
    output logic              sum_o
);

    logic [W-1:0] next_evt;
    logic [W-1:0] next_en;

    // Set wins over the clearing query
    assign next_evt = ((clr_i ? '0 : evt_o) | set_i) & USED;

    // Reading never touches the mask; zero write clears it
    always_comb begin
        next_en = en_o;
        if (en_clr_i) begin
            next_en = '0;
        end else if (en_wr_i) begin
            next_en = en_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_o <= EVT_RESET;
        end else if (ce_i) begin
            evt_o <= next_evt;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_o <= EN_RESET;
        end else if (ce_i) begin
            en_o <= next_en;
        end
    end

    // Summary tracks the contents with no extra cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sum_o <= |(EVT_RESET & EN_RESET);
        end else if (ce_i) begin
            sum_o <= |(next_evt & next_en);
        end
    end

endmodule : iser_event_latch

// ==== design/iser_msg_count.sv ====
// Purpose: Occupancy count of messages waiting in the output buffer
// Assumes: Caller blocks push when full and pop when empty
// Notes:   next_count_o lets the caller act in the same cycle
`timescale 1ns/10ps
module iser_msg_count #(
    parameter int W = 5
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic         push_i,
    input  wire logic         pop_i,
    output logic      [W-1:0] count_o,
    output logic      [W-1:0] next_count_o
);

    always_comb begin
        next_count_o = count_o;
        if (push_i && !pop_i) begin
            next_count_o = W'(count_o + 1'b1);
        end else if (pop_i && !push_i) begin
            next_count_o = W'(count_o - 1'b1);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_o <= '0;
        end else if (ce_i) begin
            count_o <= next_count_o;
        end
    end

endmodule : iser_msg_count

// ==== bench/iser_status_core_properties.sv ====
// Purpose: Port-level checks of the status and event core
// Assumes: One clock, sys_rst_i asynchronous and high
// Notes:   Summaries are compared in the same cycle as the latches
`timescale 1ns/10ps
module iser_status_properties
    import iser_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        ce_i,
    input wire iser_cmd_t   cmd_i,
    input wire logic [7:0]  ese_wdata_i,
    input wire logic        cmds_idle_i,
    input wire iser_evt_t   evt_i,
    input wire logic        reading_trigger_i,
    input wire logic        host_read_i,
    input wire logic        new_line_i,
    input wire logic        in_buf_full_i,
    input wire logic [7:0]  esr_o,
    input wire logic [15:0] ques_o,
    input wire logic [7:0]  ese_o,
    input wire logic [15:0] qen_o,
    input wire logic [7:0]  stb_o,
    input wire logic        mav_o,
    input wire logic        err_push_o,
    input wire logic        opc_pending_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // Query errors can arise from these, so they are kept out of flag checks
    logic quiet;
    assign quiet = !host_read_i && !new_line_i && !in_buf_full_i;

    sequence opc_armed;
        ce_i && cmd_i.opc && !cmds_idle_i ##1 opc_pending_o;
    endsequence
    sequence direct_trigger;
        ce_i && cmd_i.read_cmd ##2 ce_i && reading_trigger_i;
    endsequence

    unused_bits_zero_a: assert property (
        !esr_o[1] && !esr_o[6] && (ques_o & 16'hfdee) == 16'h0000)
        else $error("reserved status bit set");
    exec_error_a: assert property (
        ce_i && evt_i.exec_fail |=> esr_o[4] && err_push_o)
        else $error("execution error not flagged");
    overload_flags_a: assert property (
        ce_i && evt_i == 7'h04 && quiet |=> esr_o[3] && ques_o[0] && !err_push_o)
        else $error("overload flags wrong");
    status_clear_a: assert property (
        ce_i && cmd_i.cls && evt_i == 7'h00 && quiet
        |=> (esr_o & 8'hfe) == 8'h00 && ques_o == 16'h0000)
        else $error("clear status left bits");
    latch_hold_a: assert property (
        ce_i && !cmd_i.cls && !cmd_i.esr_query |=> (esr_o & $past(esr_o)) == $past(esr_o))
        else $error("event bit dropped");
    set_wins_a: assert property (
        ce_i && cmd_i.esr_query && evt_i.syntax_err |=> esr_o[5])
        else $error("event lost in clearing cycle");
    enable_zero_a: assert property (
        ce_i && cmd_i.ese_write && ese_wdata_i == 8'h00 |=> ese_o == 8'h00)
        else $error("enable zero write kept bits");
    preset_clear_a: assert property (
        ce_i && cmd_i.preset && !cmd_i.qen_write |=> qen_o == 16'h0000)
        else $error("preset left questionable enable");
    std_summary_a: assert property (stb_o[5] == |(esr_o & ese_o))
        else $error("standard summary wrong");
    ques_summary_a: assert property (stb_o[3] == |(ques_o & qen_o))
        else $error("questionable summary wrong");
    opc_done_a: assert property (opc_armed ##0 ce_i && cmds_idle_i |=> esr_o[0])
        else $error("operation complete not set");
    mav_first_a: assert property (direct_trigger |=> mav_o && stb_o[4])
        else $error("message available missing");
    mav_hold_a: assert property (ce_i && mav_o && !host_read_i && !cmd_i.cls |=> mav_o)
        else $error("message available dropped early");
endmodule : iser_status_properties

bind iser_status_core iser_status_properties chk_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .cmd_i(cmd_i),
    .ese_wdata_i(ese_wdata_i), .cmds_idle_i(cmds_idle_i), .evt_i(evt_i),
    .reading_trigger_i(reading_trigger_i), .host_read_i(host_read_i),
    .new_line_i(new_line_i), .in_buf_full_i(in_buf_full_i), .esr_o(esr_o),
    .ques_o(ques_o), .ese_o(ese_o), .qen_o(qen_o), .stb_o(stb_o), .mav_o(mav_o),
    .err_push_o(err_push_o), .opc_pending_o(opc_pending_o)
);

// ==== bench/iser_host_model.sv ====
// Purpose: Bus controller side: status commands and message reads
// Assumes: Strobes are one clock wide and change on the falling edge
// Notes:   Write data shows its inverse once released
`timescale 1ns/10ps
module iser_host_model
    import iser_pkg::*;
(
    input  wire logic        clk_i,
    output iser_cmd_t        cmd_o,
    output logic      [7:0]  ese_wdata_o,
    output logic      [15:0] qen_wdata_o,
    output logic             host_read_o,
    output logic             new_line_o
);
    initial begin
        cmd_o = '0;
        ese_wdata_o = 8'h00;
        qen_wdata_o = 16'h0000;
        host_read_o = 1'b0;
        new_line_o = 1'b0;
    end

    // Drive one command with its write data for one clock, then release
    task automatic send(input iser_cmd_t c, input logic [7:0] e, input logic [15:0] q);
        @(negedge clk_i);
        cmd_o = c;
        ese_wdata_o = e;
        qen_wdata_o = q;
        @(negedge clk_i);
        cmd_o = '0;
        ese_wdata_o = ~e;
        qen_wdata_o = ~q;
    endtask : send

    task automatic read_msg();
        @(negedge clk_i);
        host_read_o = 1'b1;
        @(negedge clk_i);
        host_read_o = 1'b0;
    endtask : read_msg

    task automatic new_line();
        @(negedge clk_i);
        new_line_o = 1'b1;
        @(negedge clk_i);
        new_line_o = 1'b0;
    endtask : new_line
endmodule : iser_host_model

// ==== bench/iser_status_core_tb.sv ====
// Purpose: Directed test of the status and event core
// Assumes: Power-on clear setting 1, then 0 for a second power-up; clock enable high
// Notes:   Inputs change on the falling edge, checks run there too
`timescale 1ns/10ps
module iser_status_core_tb
    import iser_pkg::*;
;
    localparam iser_cmd_t c_cls = 9'h100, c_esrq = 9'h080, c_quesq = 9'h040, c_esew = 9'h020;
    localparam iser_cmd_t c_qenw = 9'h010, c_pre = 9'h008, c_opc = 9'h004, c_rdc = 9'h002;
    localparam iser_cmd_t c_init = 9'h001;
    logic       clk_i = 1'b0, sys_rst_i = 1'b1, idle = 1'b1, trig = 1'b0, done = 1'b0;
    logic       rpush = 1'b0, qpush = 1'b0, psc = 1'b1;
    iser_evt_t  evt = '0;
    iser_cmd_t  cmd;
    logic [7:0] ese_wd, esr, ese, stb, ecode;
    logic [15:0] qen_wd, ques, qen;
    logic       hread, nline, mav, epush, halt, opcp, ofull;
    int         n_mismatch = 0, tests_run = 0;
    logic [7:0]  xe [7] = '{8'h08, 8'h08, 8'h08, 8'h20, 8'h10, 8'h08, 8'h08};
    logic [15:0] xq [7] = '{16'h0200, 16'h0010, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0};
    logic        xp [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

    always #10 clk_i = ~clk_i;

    iser_host_model host_u (.clk_i(clk_i), .cmd_o(cmd), .ese_wdata_o(ese_wd),
        .qen_wdata_o(qen_wd), .host_read_o(hread), .new_line_o(nline));

    iser_status_core dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .cmd_i(cmd),
        .ese_wdata_i(ese_wd), .qen_wdata_i(qen_wd), .psc_setting_i(psc),
        .ese_retained_i(8'h5a), .cmds_idle_i(idle), .evt_i(evt), .reading_trigger_i(trig),
        .meas_all_done_i(done), .reading_push_i(rpush), .query_push_i(qpush),
        .host_read_i(hread), .new_line_i(nline), .in_buf_full_i(1'b0), .esr_o(esr),
        .ques_o(ques), .ese_o(ese), .qen_o(qen), .stb_o(stb), .mav_o(mav),
        .err_push_o(epush), .err_code_o(ecode), .reading_halt_o(halt),
        .opc_pending_o(opcp), .out_full_o(ofull));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick();
        @(negedge clk_i);
    endtask : tick

    task automatic evt_pulse(input iser_evt_t e);
        tick();
        evt = e;
        tick();
        evt = '0;
    endtask : evt_pulse

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Bounded run: a stuck sequence ends as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("unexpected run length: expected end, seen timeout");
        complete_run();
    end

    initial begin
        repeat (5) tick();
        sys_rst_i = 1'b0;
        check("esr", 16'h80, esr);
        check("ques", 16'h0, ques);
        tick();
        check("ese", 16'h0, ese);
        check("qen", 16'h0, qen);
        host_u.send(c_esrq, 8'h00, 16'h0);
        check("esr", 16'h0, esr);
        for (int i = 0; i < 7; i++) begin
            host_u.send(c_cls, 8'h00, 16'h0);
            evt_pulse(iser_evt_t'(7'h01 << i));
            check("err_push", 16'(xp[i]), 16'(epush));
            check("err_code", xp[i] ? 16'(xe[i]) : 16'h0, 16'(ecode));
            check("esr", 16'(xe[i]), 16'(esr));
            check("ques", xq[i], ques);
        end
        evt_pulse(7'h04);
        evt_pulse(7'h10);
        check("esr", 16'h18, esr);
        check("ques", 16'h1, ques);
        host_u.send(c_quesq, 8'h00, 16'h0);
        check("ques", 16'h0, ques);
        check("esr", 16'h18, esr);
        fork
            host_u.send(c_esrq, 8'h00, 16'h0);
            evt_pulse(7'h08);
        join
        check("esr", 16'h20, esr);
        host_u.send(c_cls, 8'h00, 16'h0);
        host_u.send(c_esew, 8'h01, 16'h0);
        idle = 1'b0;
        host_u.send(c_opc, 8'h00, 16'h0);
        check("opc_pending", 16'h1, 16'(opcp));
        check("esr", 16'h0, esr);
        idle = 1'b1;
        tick();
        check("esr", 16'h1, esr);
        check("stb", 16'h20, stb);
        check("ese", 16'h1, ese);
        host_u.send(c_esrq, 8'h00, 16'h0);
        check("stb", 16'h0, stb);
        host_u.send(c_esew, 8'h00, 16'h0);
        check("ese", 16'h0, ese);
        host_u.send(c_qenw, 8'h00, 16'h0010);
        check("qen", 16'h10, qen);
        evt_pulse(7'h02);
        check("stb", 16'h08, stb);
        host_u.send(c_pre, 8'h00, 16'h0);
        check("qen", 16'h0, qen);
        check("stb", 16'h0, stb);
        host_u.send(c_cls, 8'h00, 16'h0);
        host_u.read_msg();
        check("esr", 16'h04, esr);
        check("err_code", 16'h04, 16'(ecode));
        host_u.send(c_cls, 8'h00, 16'h0);
        host_u.send(c_rdc, 8'h00, 16'h0);
        tick();
        trig = 1'b1;
        rpush = 1'b1;
        tick();
        trig = 1'b0;
        rpush = 1'b0;
        check("stb", 16'h10, stb);
        host_u.read_msg();
        check("mav", 16'h0, 16'(mav));
        check("esr", 16'h0, esr);
        idle = 1'b0;
        host_u.send(c_opc, 8'h00, 16'h0);
        qpush = 1'b1;
        repeat (16) tick();
        qpush = 1'b0;
        check("out_full", 16'h1, 16'(ofull));
        check("reading_halt", 16'h1, 16'(halt));
        host_u.new_line();
        check("esr", 16'h04, esr);
        repeat (15) host_u.read_msg();
        check("mav", 16'h1, 16'(mav));
        host_u.read_msg();
        check("mav", 16'h0, 16'(mav));
        idle = 1'b1;
        host_u.send(c_init, 8'h00, 16'h0);
        tick();
        trig = 1'b1;
        tick();
        trig = 1'b0;
        check("mav", 16'h0, 16'(mav));
        done = 1'b1;
        tick();
        done = 1'b0;
        check("mav", 16'h1, 16'(mav));
        psc = 1'b0;
        sys_rst_i = 1'b1;
        repeat (2) tick();
        sys_rst_i = 1'b0;
        tick();
        check("ese", 16'h5a, ese);
        check("esr", 16'h80, esr);
        complete_run();
    end
endmodule : iser_status_core_tb
